/* acl_data_packet_header_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "alh_defines.svh"

module acl_data_packet_header_tb_top;
  import alh_pkg::*;

  logic        clock, rst, tx_hdr_valid, link_valid, link_up, rx_valid;
  logic        chk_valid, chk_drained_event, reg_write, reg_read;
  logic        fwd_valid_q, fwd_drop_q, conn_report_q, conn_refused_q;
  logic        up_valid_q, chk_done_q, chk_ok_q;
  logic [1:0]  fwd_lane_q;
  logic [7:0]  reg_addr;
  logic [11:0] link_handle, chk_handle, conn_handle_q, ha, hp;
  logic [31:0] reg_wdata, reg_rdata_q, h, r;
  alh_hdr_t    tx_hdr, fwd_q, up_hdr_q;
  alh_rx_t     rx_desc;
  int          n_mismatch, n_checks;

  alh_framer i_dut (.clock(clock), .rst(rst), .tx_hdr_valid(tx_hdr_valid),
    .tx_hdr(tx_hdr), .fwd_valid_q(fwd_valid_q), .fwd_q(fwd_q), .fwd_lane_q(fwd_lane_q),
    .fwd_drop_q(fwd_drop_q), .link_valid(link_valid), .link_up(link_up),
    .link_handle(link_handle), .conn_report_q(conn_report_q), .conn_handle_q(conn_handle_q),
    .conn_refused_q(conn_refused_q), .rx_valid(rx_valid), .rx_desc(rx_desc),
    .up_valid_q(up_valid_q), .up_hdr_q(up_hdr_q), .chk_valid(chk_valid),
    .chk_handle(chk_handle), .chk_drained_event(chk_drained_event),
    .chk_done_q(chk_done_q), .chk_ok_q(chk_ok_q), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_q(reg_rdata_q));

  alh_host_model i_host (.clock(clock), .conn_report_q(conn_report_q),
    .conn_handle_q(conn_handle_q), .tx_hdr(tx_hdr), .tx_hdr_valid(tx_hdr_valid));

  always #50 clock = ~clock;

  task automatic final_report;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    cmp(reg_rdata_q, exp);
  endtask

  task automatic hdr(input logic [31:0] hh, input logic ok, input logic [1:0] ln);
    i_host.send_raw(hh);
    @(posedge clock);
    #1;
    cmp({fwd_valid_q, fwd_drop_q}, {ok, !ok});
    if (ok) begin
      cmp(fwd_q, hh);
      cmp(fwd_lane_q, ln);
    end
  endtask

  task automatic lnk(input logic [11:0] hd, input logic ok);
    @(posedge clock);
    link_valid <= 1'b1;
    link_up <= 1'b1;
    link_handle <= hd;
    @(posedge clock);
    link_valid <= 1'b0;
    #1;
    cmp({conn_report_q, conn_refused_q, conn_handle_q}, {ok, !ok, hd});
  endtask

  task automatic chk(input logic [11:0] hd, input logic dr, input logic ok);
    @(posedge clock);
    chk_valid <= 1'b1;
    chk_handle <= hd;
    chk_drained_event <= dr;
    @(posedge clock);
    chk_valid <= 1'b0;
    #1;
    cmp({chk_done_q, chk_ok_q}, {1'b1, ok});
  endtask

  function automatic logic [31:0] up_exp(input logic [31:0] d);
    logic [1:0] c;
    c = !d[15] ? `ALH_BC_P2P : (d[14] ? `ALH_BC_PICONET : `ALH_BC_ACTIVE);
    return {d[31:16], c, d[13:12], d[11:0]};
  endfunction

  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {tx_hdr_valid, link_valid, link_up, rx_valid, chk_valid} = '0;
    {chk_drained_event, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {link_handle, chk_handle, rx_desc} = '0;
    void'($urandom(32'h703909a1));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(`ALH_REG_STATUS, 32'h0);
    rd(`ALH_REG_BHANDLE, 32'h0);
    rd(8'h0c, 32'h0);
    for (int i = 0; i < 8; i++) begin
      h = $urandom;
      h[15:14] = `ALH_BC_P2P;
      h[13:12] = h[0] ? `ALH_PB_FIRST : `ALH_PB_CONT;
      h[11:8] = 4'h0;
      hdr(h, 1'b1, `ALH_LANE_CONN);
    end
    hdr({16'h0010, `ALH_BC_P2P, `ALH_PB_FIRST, 12'hf00}, 1'b0, 2'h0);
    hdr({16'h0010, `ALH_BC_RSV, `ALH_PB_FIRST, 12'h010}, 1'b0, 2'h0);
    i_host.pick(0, ha);
    hdr({16'h0020, `ALH_BC_ACTIVE, `ALH_PB_FIRST, ha}, 1'b1, `ALH_LANE_ACTIVE);
    hdr({16'h0021, `ALH_BC_ACTIVE, `ALH_PB_CONT, ha}, 1'b1, `ALH_LANE_ACTIVE);
    hdr({16'h0022, `ALH_BC_ACTIVE, `ALH_PB_FIRST, ha + 12'h1}, 1'b0, 2'h0);
    hdr({16'h0023, `ALH_BC_PICONET, `ALH_PB_FIRST, ha}, 1'b0, 2'h0);
    rd(`ALH_REG_STATUS, 32'h31);
    wr(`ALH_REG_STATUS, 32'h30);
    rd(`ALH_REG_STATUS, 32'h01);
    lnk(ha, 1'b0);
    lnk(12'hf00, 1'b0);
    lnk(12'h050, 1'b1);
    chk(ha, 1'b0, 1'b0);
    chk(ha, 1'b1, 1'b1);
    chk(12'hf00, 1'b0, 1'b0);
    chk(12'h050, 1'b0, 1'b1);
    fork
      lnk(12'h300, 1'b1);
      begin
        @(posedge clock);
        hdr({16'h0008, `ALH_BC_PICONET, `ALH_PB_FIRST, 12'h300}, 1'b1, `ALH_LANE_PICONET);
      end
    join
    rd(`ALH_REG_STATUS, 32'h0b);
    chk(12'h300, 1'b1, 1'b1);
    i_host.pick(1, hp);
    hdr({16'h0009, `ALH_BC_PICONET, `ALH_PB_FIRST, hp}, 1'b1, `ALH_LANE_PICONET);
    rd(`ALH_REG_STATUS, 32'h03);
    hdr({16'h000a, `ALH_BC_P2P, `ALH_PB_FIRST, 12'h300}, 1'b1, `ALH_LANE_CONN);
    rd(`ALH_REG_BHANDLE, {4'h0, hp, 4'h0, ha});
    wr(`ALH_REG_CTRL, 32'h1);
    hdr({16'h0004, `ALH_BC_P2P, 2'h0, 12'h020}, 1'b0, 2'h0);
    wr(`ALH_REG_CTRL, 32'h0);
    hdr({16'h0005, `ALH_BC_P2P, 2'h3, 12'h021}, 1'b1, `ALH_LANE_CONN);
    rd(`ALH_REG_STATUS, 32'h13);
    wr(`ALH_REG_STATUS, 32'h10);
    rd(`ALH_REG_STATUS, 32'h03);
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      if (i < 3) begin
        r[15:14] = {i > 0, i == 2};
      end
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_desc <= alh_rx_t'(r);
      @(posedge clock);
      rx_valid <= 1'b0;
      #1;
      cmp({up_valid_q, up_hdr_q}, {1'b1, up_exp(r)});
    end
    final_report();
  end
endmodule

`default_nettype wire

/* alh_defines.svh */
`ifndef ALH_DEFINES_SVH
`define ALH_DEFINES_SVH

// Header field widths.
`define ALH_HANDLE_W      12
`define ALH_CODE_W        2
`define ALH_LEN_W         16
`define ALH_HDR_W         32

// Handle range: anything above the maximum is reserved.
`define ALH_HANDLE_MAX    12'heff

// Fragment boundary codes.
`define ALH_PB_CONT       2'h1
`define ALH_PB_FIRST      2'h2

// Broadcast codes, both directions.
`define ALH_BC_P2P        2'h0
`define ALH_BC_ACTIVE     2'h1
`define ALH_BC_PICONET    2'h2
`define ALH_BC_RSV        2'h3

// Delivery lanes of packets taken from the host.
`define ALH_LANE_CONN     2'h0
`define ALH_LANE_ACTIVE   2'h1
`define ALH_LANE_PICONET  2'h2

// Broadcast slot indices.
`define ALH_SLOT_ACTIVE   1'h0
`define ALH_SLOT_PICONET  1'h1

// Register byte offsets.
`define ALH_REG_CTRL      8'h00
`define ALH_REG_STATUS    8'h04
`define ALH_REG_BHANDLE   8'h08

// Register bit positions.
`define ALH_CTRL_DROP_RSV 0
`define ALH_ST_BOUND_LSB  0
`define ALH_ST_COLL_LSB   2
`define ALH_ST_ERR_RSV    4
`define ALH_ST_ERR_BIND   5
`define ALH_BH_PIC_LSB    16

// Handle map geometry.
`define ALH_MAP_DEPTH     4096

`endif

/* alh_framer.sv */
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "alh_defines.svh"

module alh_framer (
  input  wire logic               clock,             // System clock, 10 MHz.
  input  wire logic               rst,               // Synchronous reset, active high.
  input  wire logic               tx_hdr_valid,      // Host packet header present.
  input  wire alh_pkg::alh_hdr_t  tx_hdr,            // Host packet header.
  output logic                    fwd_valid_q,       // Accepted header out, pulse.
  output alh_pkg::alh_hdr_t       fwd_q,             // Accepted header.
  output logic [1:0]              fwd_lane_q,        // Delivery lane of the header.
  output logic                    fwd_drop_q,        // Header refused, pulse.
  input  wire logic               link_valid,        // Link change from link manager.
  input  wire logic               link_up,           // 1 link completed, 0 link gone.
  input  wire logic [11:0]        link_handle,       // Handle of the link.
  output logic                    conn_report_q,     // Report completed link, pulse.
  output logic [11:0]             conn_handle_q,     // Handle of reported link.
  output logic                    conn_refused_q,    // Completed link withheld, pulse.
  input  wire logic               rx_valid,          // Received packet present.
  input  wire alh_pkg::alh_rx_t   rx_desc,           // Received packet description.
  output logic                    up_valid_q,        // Upward header out, pulse.
  output alh_pkg::alh_hdr_t       up_hdr_q,          // Upward header.
  input  wire logic               chk_valid,         // Handle check request.
  input  wire logic [11:0]        chk_handle,        // Handle in a command or event.
  input  wire logic               chk_drained_event, // Request is a drained count event.
  output logic                    chk_done_q,        // Check answer, pulse.
  output logic                    chk_ok_q,          // Handle may be used.
  input  wire logic [7:0]         reg_addr,          // Register byte address.
  input  wire logic [31:0]        reg_wdata,         // Register write data.
  input  wire logic               reg_write,         // Register write strobe.
  input  wire logic               reg_read,          // Register read strobe.
  output logic [31:0]             reg_rdata_q        // Read data, cycle after strobe.
);
  import alh_pkg::*;

  alh_state_t st_q;
  alh_state_t st_d;
  logic       map_bit_q;
  logic       map_wr_en;
  logic       link_ok;

  function automatic logic rsv_handle(input logic [`ALH_HANDLE_W-1:0] h);
    return h > `ALH_HANDLE_MAX;
  endfunction

  function automatic logic bcast_hit(input logic [`ALH_HANDLE_W-1:0] h,
                                     input alh_state_t s);
    return (s.bound[0] && s.bnd_handle[0] == h) ||
           (s.bound[1] && s.bnd_handle[1] == h);
  endfunction

  assign link_ok   = !rsv_handle(link_handle) && !bcast_hit(link_handle, st_q);
  assign map_wr_en = link_valid && (!link_up || link_ok);

  alh_handle_map #(
    .DEPTH (`ALH_MAP_DEPTH),
    .AW    (`ALH_HANDLE_W)
  ) u_map (
    .clock    (clock),
    .rst      (rst),
    .wr_en    (map_wr_en),
    .wr_addr  (link_handle),
    .wr_bit   (link_up),
    .rd_addr  (tx_hdr.handle),
    .rd_bit_q (map_bit_q)
  );

  always_comb begin
    logic                     asg;
    logic                     drop;
    logic                     slot;
    logic [`ALH_HANDLE_W-1:0] h;
    asg  = 1'b0;
    drop = 1'b0;
    slot = `ALH_SLOT_ACTIVE;
    h    = st_q.s1_hdr.handle;
    st_d = st_q;

    st_d.fwd_valid   = 1'b0;
    st_d.fwd_drop    = 1'b0;
    st_d.rep_valid   = 1'b0;
    st_d.rep_refused = 1'b0;
    st_d.up_valid    = 1'b0;
    st_d.chk_done    = 1'b0;

    // Register writes go first so that an error raised below wins over its clear.
    if (reg_write) begin
      if (reg_addr == `ALH_REG_CTRL) begin
        st_d.drop_rsv_en = reg_wdata[`ALH_CTRL_DROP_RSV];
      end else if (reg_addr == `ALH_REG_STATUS) begin
        if (reg_wdata[`ALH_ST_ERR_RSV]) begin
          st_d.err_rsv = 1'b0;
        end
        if (reg_wdata[`ALH_ST_ERR_BIND]) begin
          st_d.err_bind = 1'b0;
        end
      end
    end

    // Stage 0: capture the header while the handle map is read.
    st_d.s1_valid   = tx_hdr_valid;
    st_d.s1_hdr     = tx_hdr;
    st_d.s1_fwd_hit = map_wr_en && link_handle == tx_hdr.handle;
    st_d.s1_fwd_bit = link_up;

    // Stage 1: the map answer may be stale by two writes, so both recent writes bypass it.
    asg = st_q.s1_fwd_hit ? st_q.s1_fwd_bit : map_bit_q;
    if (map_wr_en && link_handle == h) begin
      asg = link_up;
    end
    slot = (st_q.s1_hdr.bc == `ALH_BC_PICONET);

    if (st_q.s1_valid) begin
      if (rsv_handle(h)) begin
        drop = 1'b1;
        st_d.err_rsv = 1'b1;
      end else if (st_q.s1_hdr.bc == `ALH_BC_RSV) begin
        drop = 1'b1;
        st_d.err_rsv = 1'b1;
      end
      if (st_q.s1_hdr.pb != `ALH_PB_CONT && st_q.s1_hdr.pb != `ALH_PB_FIRST) begin
        st_d.err_rsv = 1'b1;
        if (st_q.drop_rsv_en) begin
          drop = 1'b1;
        end
      end
      if (!drop && st_q.s1_hdr.bc != `ALH_BC_P2P) begin
        if (!st_q.bound[slot] || (st_q.coll[slot] && h != st_q.bnd_handle[slot])) begin
          if (st_q.bound[!slot] && st_q.bnd_handle[!slot] == h) begin
            drop = 1'b1;
            st_d.err_bind = 1'b1;
          end else begin
            // rebind after collision, an assigned handle marks a collision
            st_d.bound[slot]      = 1'b1;
            st_d.bnd_handle[slot] = h;
            st_d.coll[slot]       = asg;
          end
        end else if (h != st_q.bnd_handle[slot]) begin
          drop = 1'b1;
          st_d.err_bind = 1'b1;
        end
      end
      st_d.fwd_valid = !drop;
      st_d.fwd_drop  = drop;
      st_d.fwd       = st_q.s1_hdr;
      // broadcast lanes kept apart from the link of the same handle
      if (st_q.s1_hdr.bc == `ALH_BC_ACTIVE) begin
        st_d.fwd_lane = `ALH_LANE_ACTIVE;
      end else if (st_q.s1_hdr.bc == `ALH_BC_PICONET) begin
        st_d.fwd_lane = `ALH_LANE_PICONET;
      end else begin
        st_d.fwd_lane = `ALH_LANE_CONN;
      end
    end

    // report or withhold a completed link
    if (link_valid && link_up) begin
      st_d.rep_valid   = link_ok;
      st_d.rep_refused = !link_ok;
      st_d.rep_handle  = link_handle;
    end

    // upward header uses the master link
    if (rx_valid) begin
      st_d.up_valid      = 1'b1;
      st_d.up_hdr.handle = rx_desc.master_handle;
      st_d.up_hdr.pb     = rx_desc.pb;
      st_d.up_hdr.len    = rx_desc.len;
      if (!rx_desc.bcast) begin
        st_d.up_hdr.bc = `ALH_BC_P2P;
      end else if (rx_desc.parked) begin
        st_d.up_hdr.bc = `ALH_BC_PICONET;
      end else begin
        st_d.up_hdr.bc = `ALH_BC_ACTIVE;
      end
    end

    if (chk_valid) begin
      st_d.chk_done = 1'b1;
      st_d.chk_ok   = !rsv_handle(chk_handle) &&
                      (!bcast_hit(chk_handle, st_q) || chk_drained_event);
    end

    st_d.rdata = '0;
    if (reg_read) begin
      if (reg_addr == `ALH_REG_CTRL) begin
        st_d.rdata[`ALH_CTRL_DROP_RSV] = st_q.drop_rsv_en;
      end else if (reg_addr == `ALH_REG_STATUS) begin
        st_d.rdata[`ALH_ST_BOUND_LSB +: 2] = st_q.bound;
        st_d.rdata[`ALH_ST_COLL_LSB +: 2]  = st_q.coll;
        st_d.rdata[`ALH_ST_ERR_RSV]        = st_q.err_rsv;
        st_d.rdata[`ALH_ST_ERR_BIND]       = st_q.err_bind;
      end else if (reg_addr == `ALH_REG_BHANDLE) begin
        st_d.rdata[0 +: `ALH_HANDLE_W]              = st_q.bnd_handle[0];
        st_d.rdata[`ALH_BH_PIC_LSB +: `ALH_HANDLE_W] = st_q.bnd_handle[1];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fwd_valid_q    = st_q.fwd_valid;
  assign fwd_q          = st_q.fwd;
  assign fwd_lane_q     = st_q.fwd_lane;
  assign fwd_drop_q     = st_q.fwd_drop;
  assign conn_report_q  = st_q.rep_valid;
  assign conn_handle_q  = st_q.rep_handle;
  assign conn_refused_q = st_q.rep_refused;
  assign up_valid_q     = st_q.up_valid;
  assign up_hdr_q       = st_q.up_hdr;
  assign chk_done_q     = st_q.chk_done;
  assign chk_ok_q       = st_q.chk_ok;
  assign reg_rdata_q    = st_q.rdata;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_handle_range;
    fwd_valid_q |-> fwd_q.handle <= `ALH_HANDLE_MAX;
  endproperty
  a_handle_range: assert property (p_handle_range)
    else $error("forwarded header carries a reserved handle");

  property p_no_bcast_report;
    conn_report_q |-> !$past(bcast_hit(link_handle, st_q)) && $past(link_handle) == conn_handle_q;
  endproperty
  a_no_bcast_report: assert property (p_no_bcast_report)
    else $error("completed link reported with a broadcast handle");

  property p_binding_kept;
    st_q.bound[0] && !st_q.coll[0] |=> st_q.bound[0] && $stable(st_q.bnd_handle[0]);
  endproperty
  a_binding_kept: assert property (p_binding_kept)
    else $error("active broadcast binding changed without collision");

  property p_up_handle;
    rx_valid |=> up_valid_q && up_hdr_q.handle == $past(rx_desc.master_handle);
  endproperty
  a_up_handle: assert property (p_up_handle)
    else $error("upward header lost the master link handle");

  property p_up_code;
    up_valid_q |-> up_hdr_q.bc != `ALH_BC_RSV &&
      (up_hdr_q.bc == `ALH_BC_PICONET) == ($past(rx_desc.bcast) && $past(rx_desc.parked));
  endproperty
  a_up_code: assert property (p_up_code)
    else $error("upward broadcast code wrong");

  property p_chk;
    chk_valid && bcast_hit(chk_handle, st_q) |=> chk_done_q && chk_ok_q == $past(chk_drained_event);
  endproperty
  a_chk: assert property (p_chk)
    else $error("broadcast handle passed a check");

  property p_strict_pb;
    fwd_valid_q && $past(st_q.drop_rsv_en) |->
      fwd_q.pb == `ALH_PB_CONT || fwd_q.pb == `ALH_PB_FIRST;
  endproperty
  a_strict_pb: assert property (p_strict_pb)
    else $error("reserved boundary code forwarded in strict mode");

  property p_lane;
    fwd_valid_q |-> fwd_q.bc != `ALH_BC_RSV &&
      (fwd_lane_q == `ALH_LANE_CONN) == (fwd_q.bc == `ALH_BC_P2P);
  endproperty
  a_lane: assert property (p_lane)
    else $error("broadcast and link traffic share a lane");

  property p_tx_latency;
    tx_hdr_valid |-> ##2 (fwd_valid_q ^ fwd_drop_q) && fwd_q == $past(tx_hdr, 2);
  endproperty
  a_tx_latency: assert property (p_tx_latency)
    else $error("host header not answered two cycles later");

endmodule

`default_nettype wire

/* alh_handle_map.sv */
`timescale 1ns/10ps
`default_nettype none
`include "alh_defines.svh"

// One bit per handle: set while the reported link owning that handle is up.
module alh_handle_map #(
  parameter int DEPTH = `ALH_MAP_DEPTH,
  parameter int AW    = `ALH_HANDLE_W
) (
  input  wire logic          clock,    // System clock.
  input  wire logic          rst,      // Synchronous reset, clears every entry.
  input  wire logic          wr_en,    // Write strobe.
  input  wire logic [AW-1:0] wr_addr,  // Handle to write.
  input  wire logic          wr_bit,   // New assigned state.
  input  wire logic [AW-1:0] rd_addr,  // Handle to look up.
  output logic               rd_bit_q  // Assigned state, one cycle after rd_addr.
);
  import alh_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0] bits;
    logic             rd;
  } alh_map_state_t;

  alh_map_state_t st_q;
  alh_map_state_t st_d;

  // A read in the cycle of a write to the same entry returns the old value.
  always_comb begin
    st_d    = st_q;
    st_d.rd = st_q.bits[rd_addr];
    if (wr_en) begin
      st_d.bits[wr_addr] = wr_bit;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_bit_q = st_q.rd;

endmodule

`default_nettype wire

/* alh_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Host side: issues packet headers and chooses broadcast handles.
module alh_host_model (
  input  wire logic                clock,         // System clock.
  input  wire logic                conn_report_q, // Completed link reported.
  input  wire logic [11:0]         conn_handle_q, // Handle of that link.
  output var  alh_pkg::alh_hdr_t   tx_hdr,        // Header to the controller.
  output var  logic                tx_hdr_valid   // Header present.
);
  import alh_pkg::*;

  logic [4095:0]    used;
  logic [1:0][11:0] bnd;
  logic [1:0]       has;
  logic [11:0]      nxt;

  initial begin
    used = '0;
    has = '0;
    nxt = 12'h400;
    tx_hdr = '0;
    tx_hdr_valid = 1'b0;
  end

  always @(posedge clock) begin
    if (conn_report_q) begin
      used[conn_handle_q] <= 1'b1;
    end
  end

  // Broadcasts are recorded so that later choices keep the binding.
  task automatic send_raw(input alh_hdr_t h);
    @(posedge clock);
    tx_hdr_valid <= 1'b1;
    tx_hdr <= h;
    if (h.bc == 2'h1 || h.bc == 2'h2) begin
      bnd[h.bc - 2'h1] = h.handle;
      has[h.bc - 2'h1] = 1'b1;
    end
    @(posedge clock);
    tx_hdr_valid <= 1'b0;
    // A released bus must not keep showing the old header.
    tx_hdr <= ~h;
  endtask

  task automatic pick(input int t, output logic [11:0] hd);
    while (used[nxt] || (has[1-t] && bnd[1-t] == nxt)) begin
      nxt++;
    end
    bnd[t] = nxt;
    has[t] = 1'b1;
    hd = nxt;
    nxt++;
  endtask
endmodule

`default_nettype wire

/* alh_pkg.sv */
`include "alh_defines.svh"
`default_nettype none

package alh_pkg;

  // First word carries handle, boundary and broadcast codes; the length follows.
  typedef struct packed {
    logic [`ALH_LEN_W-1:0]    len;
    logic [`ALH_CODE_W-1:0]   bc;
    logic [`ALH_CODE_W-1:0]   pb;
    logic [`ALH_HANDLE_W-1:0] handle;
  } alh_hdr_t;

  // A packet received over the air, as the baseband reports it.
  typedef struct packed {
    logic [`ALH_LEN_W-1:0]    len;
    logic                     bcast;
    logic                     parked;
    logic [`ALH_CODE_W-1:0]   pb;
    logic [`ALH_HANDLE_W-1:0] master_handle;
  } alh_rx_t;

  typedef struct packed {
    logic                       s1_valid;
    alh_hdr_t                   s1_hdr;
    logic                       s1_fwd_hit;
    logic                       s1_fwd_bit;
    logic [1:0]                 bound;
    logic [1:0][`ALH_HANDLE_W-1:0] bnd_handle;
    logic [1:0]                 coll;
    logic                       err_rsv;
    logic                       err_bind;
    logic                       drop_rsv_en;
    logic                       fwd_valid;
    alh_hdr_t                   fwd;
    logic [`ALH_CODE_W-1:0]     fwd_lane;
    logic                       fwd_drop;
    logic                       rep_valid;
    logic [`ALH_HANDLE_W-1:0]   rep_handle;
    logic                       rep_refused;
    logic                       up_valid;
    alh_hdr_t                   up_hdr;
    logic                       chk_done;
    logic                       chk_ok;
    logic [31:0]                rdata;
  } alh_state_t;

endpackage

`default_nettype wire
